/* rtl/cgc_config_regs.v */
`timescale 1ns/1ps
`include "cgc_regs.vh"

module cgc_config_regs #(
  parameter [6:0] SLAVE_ADDR = `CGC_SLAVE_ADDR
) (
  input wire mclk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire alt_freq_select_pin,
  input wire ref_div_tick,
  input wire [5:0] norm_pll1_loop_ratio,
  input wire [7:0] norm_ch0_div,
  input wire [7:0] norm_ch1_div,
  input wire [5:0] norm_pll2_loop_ratio,
  input wire [11:0] norm_sigma_delta_numerator,
  input wire [11:0] norm_sigma_delta_denominator,
  output reg [2:0] ch0_vco_div,
  output reg [4:0] ch0_out_div,
  output reg [2:0] ch1_vco_div,
  output reg [4:0] ch1_out_div,
  output reg [2:0] ch2_vco_div,
  output reg [4:0] ch2_out_div,
  output reg [2:0] ch3_vco_div,
  output reg [4:0] ch3_out_div,
  output reg [5:0] pll1_loop_ratio,
  output reg [5:0] pll2_loop_ratio,
  output reg [11:0] sigma_delta_numerator,
  output reg [11:0] sigma_delta_denominator,
  output wire pll2_channel_align,
  output wire [7:0] spread_step_size,
  output wire [8:0] spread_step_count,
  output wire [6:0] spread_update_divisor,
  output reg spread_update_tick,
  output wire [2:0] pll1_output_style,
  output wire [2:0] pll2_output_style,
  output wire ch2_powerdown,
  output wire ch3_powerdown,
  output wire refclk_output_off,
  output wire pll1_off,
  output wire pll2_off,
  output wire ref_div_by_two
);

  wire wr_strobe;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;

  reg [7:0] ch2_div_reg;
  reg [7:0] ch3_div_reg;
  reg sync_reg;
  reg [7:0] step_size_reg;
  reg [7:0] count_high_reg;
  reg [7:0] count_low_rate_reg;
  reg [5:0] alt_pll1_fb_reg;
  reg [7:0] alt_ch0_div_reg;
  reg [7:0] alt_ch1_div_reg;
  reg [5:0] alt_pll2_fb_reg;
  reg [7:0] alt_num_high_reg;
  reg [7:0] alt_num_den_reg;
  reg [7:0] alt_den_low_reg;
  reg [7:0] alt_ch3_div_reg;
  reg [7:0] alt_ch2_div_reg;
  reg [7:0] format_pd_reg;
  reg ref_out_pd_reg;
  reg [2:0] pll_pd_reg;
  reg [6:0] tick_cnt_reg;
  reg [6:0] tick_cnt_next;
  reg tick_next;

  wire [11:0] ch0_sel;
  wire [11:0] ch1_sel;
  wire [11:0] ch2_sel;
  wire [11:0] ch3_sel;
  wire [11:0] pll1_sel;
  wire [11:0] pll2_sel;

  // Picks the alternate value when the select pin is high.
  function [11:0] pick_set;
    input use_alt;
    input [11:0] alt_val;
    input [11:0] norm_val;
    begin
      pick_set = use_alt ? alt_val : norm_val;
    end
  endfunction

  cgc_i2c_write #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_i2c (
    .mclk(mclk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_strobe(wr_strobe),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // Addresses outside this bank are ignored.
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      ch2_div_reg <= `CGC_RST_CH2_DIV;
      ch3_div_reg <= `CGC_RST_CH3_DIV;
      sync_reg <= 1'b0;
      step_size_reg <= 8'h00;
      count_high_reg <= 8'h00;
      count_low_rate_reg <= 8'h00;
      alt_pll1_fb_reg <= `CGC_RST_ALT_PLL1_FB;
      alt_ch0_div_reg <= `CGC_RST_ALT_CH0_DIV;
      alt_ch1_div_reg <= `CGC_RST_ALT_CH1_DIV;
      alt_pll2_fb_reg <= `CGC_RST_ALT_PLL2_FB;
      alt_num_high_reg <= 8'h00;
      alt_num_den_reg <= 8'h00;
      alt_den_low_reg <= 8'h00;
      alt_ch3_div_reg <= `CGC_RST_ALT_CH3_DIV;
      alt_ch2_div_reg <= `CGC_RST_ALT_CH2_DIV;
      format_pd_reg <= 8'h00;
      ref_out_pd_reg <= 1'b0;
      pll_pd_reg <= 3'h0;
    end
    else if (wr_strobe)
    begin
      case (wr_addr)
        // [RULE_01] Channel 2 divider.
        `CGC_OFF_CH2_DIV:
        begin
          ch2_div_reg <= wr_data;
        end
        // [RULE_02] Channel 3 divider.
        `CGC_OFF_CH3_DIV:
        begin
          ch3_div_reg <= wr_data;
        end
        `CGC_OFF_CH_SYNC:
        begin
          sync_reg <= wr_data[`CGC_BIT_SYNC];
        end
        // [RULE_03] Signed step size.
        `CGC_OFF_STEP_SIZE:
        begin
          step_size_reg <= wr_data;
        end
        // [RULE_04] Step count high bits.
        `CGC_OFF_COUNT_HIGH:
        begin
          count_high_reg <= wr_data;
        end
        `CGC_OFF_COUNT_LOW_RATE:
        begin
          count_low_rate_reg <= wr_data;
        end
        // [RULE_06] Alternate PLL1 ratio.
        `CGC_OFF_ALT_PLL1_FB:
        begin
          alt_pll1_fb_reg <= wr_data[5:0];
        end
        // [RULE_07] Alternate channel 0/1.
        `CGC_OFF_ALT_CH0_DIV:
        begin
          alt_ch0_div_reg <= wr_data;
        end
        `CGC_OFF_ALT_CH1_DIV:
        begin
          alt_ch1_div_reg <= wr_data;
        end
        // [RULE_08] Alternate PLL2 ratio.
        `CGC_OFF_ALT_PLL2_FB:
        begin
          alt_pll2_fb_reg <= wr_data[5:0];
        end
        // [RULE_09] Fraction word bytes.
        `CGC_OFF_ALT_NUM_HIGH:
        begin
          alt_num_high_reg <= wr_data;
        end
        `CGC_OFF_ALT_NUM_DEN:
        begin
          alt_num_den_reg <= wr_data;
        end
        `CGC_OFF_ALT_DEN_LOW:
        begin
          alt_den_low_reg <= wr_data;
        end
        // [RULE_10] Alternate channel 3/2.
        `CGC_OFF_ALT_CH3_DIV:
        begin
          alt_ch3_div_reg <= wr_data;
        end
        `CGC_OFF_ALT_CH2_DIV:
        begin
          alt_ch2_div_reg <= wr_data;
        end
        // [RULE_11] Format and powerdown.
        `CGC_OFF_FORMAT_PD:
        begin
          format_pd_reg <= wr_data;
        end
        `CGC_OFF_REF_OUT_PD:
        begin
          ref_out_pd_reg <= wr_data[`CGC_BIT_REF_OUT_PD];
        end
        // [RULE_13] PLL powerdown bits.
        `CGC_OFF_PLL_PD:
        begin
          pll_pd_reg <= wr_data[`CGC_BIT_PLL1_PD:`CGC_BIT_REF_DIV];
        end
        default:
        begin
          sync_reg <= sync_reg;
        end
      endcase
    end
  end

  // [RULE_12] Pin selects set.
  assign ch0_sel = pick_set(alt_freq_select_pin, {4'h0, alt_ch0_div_reg}, {4'h0, norm_ch0_div});
  assign ch1_sel = pick_set(alt_freq_select_pin, {4'h0, alt_ch1_div_reg}, {4'h0, norm_ch1_div});
  assign ch2_sel = pick_set(alt_freq_select_pin, {4'h0, alt_ch2_div_reg}, {4'h0, ch2_div_reg});
  assign ch3_sel = pick_set(alt_freq_select_pin, {4'h0, alt_ch3_div_reg}, {4'h0, ch3_div_reg});
  assign pll1_sel = pick_set(alt_freq_select_pin, {6'h00, alt_pll1_fb_reg}, {6'h00, norm_pll1_loop_ratio});
  assign pll2_sel = pick_set(alt_freq_select_pin, {6'h00, alt_pll2_fb_reg}, {6'h00, norm_pll2_loop_ratio});

  // Registering the selected set keeps a pin glitch from reaching the dividers combinationally.
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      ch0_vco_div <= 3'h0;
      ch0_out_div <= 5'h00;
      ch1_vco_div <= 3'h0;
      ch1_out_div <= 5'h00;
      ch2_vco_div <= 3'h0;
      ch2_out_div <= 5'h00;
      ch3_vco_div <= 3'h0;
      ch3_out_div <= 5'h00;
      pll1_loop_ratio <= 6'h00;
      pll2_loop_ratio <= 6'h00;
      sigma_delta_numerator <= 12'h000;
      sigma_delta_denominator <= 12'h000;
    end
    else
    begin
      // [RULE_07] Channel 0/1 fields.
      {ch0_vco_div, ch0_out_div} <= ch0_sel[7:0];
      {ch1_vco_div, ch1_out_div} <= ch1_sel[7:0];
      // [RULE_10] Channel 2/3 fields.
      {ch2_vco_div, ch2_out_div} <= ch2_sel[7:0];
      {ch3_vco_div, ch3_out_div} <= ch3_sel[7:0];
      // [RULE_06] PLL1 ratio select.
      pll1_loop_ratio <= pll1_sel[5:0];
      // [RULE_08] PLL2 ratio select.
      pll2_loop_ratio <= pll2_sel[5:0];
      // [RULE_09] Assemble numerator, denominator.
      sigma_delta_numerator <= pick_set(alt_freq_select_pin, {alt_num_high_reg, alt_num_den_reg[7:4]},
        norm_sigma_delta_numerator);
      sigma_delta_denominator <= pick_set(alt_freq_select_pin, {alt_num_den_reg[3:0], alt_den_low_reg},
        norm_sigma_delta_denominator);
    end
  end

  // [RULE_04] Nine-bit count assembly.
  assign spread_step_count = {count_high_reg, count_low_rate_reg[`CGC_BIT_COUNT_LSB]};
  assign spread_update_divisor = count_low_rate_reg[6:0];
  assign spread_step_size = step_size_reg;
  assign pll2_channel_align = sync_reg;
  assign pll1_output_style = format_pd_reg[2:0];
  assign pll2_output_style = format_pd_reg[5:3];
  assign ch2_powerdown = format_pd_reg[`CGC_BIT_CH2_PD];
  assign ch3_powerdown = format_pd_reg[`CGC_BIT_CH3_PD];
  assign refclk_output_off = ref_out_pd_reg;
  assign pll1_off = pll_pd_reg[2];
  assign pll2_off = pll_pd_reg[1];
  assign ref_div_by_two = pll_pd_reg[0];

  // [RULE_05] Update tick divider.
  // A divisor of zero halts updates, so a cleared register cannot sweep the fraction.
  always @*
  begin
    tick_cnt_next = tick_cnt_reg;
    tick_next = 1'b0;
    if (spread_update_divisor == 7'h00)
    begin
      tick_cnt_next = 7'h00;
    end
    else if (ref_div_tick)
    begin
      if (tick_cnt_reg >= spread_update_divisor - 7'h01)
      begin
        tick_cnt_next = 7'h00;
        tick_next = 1'b1;
      end
      else
      begin
        tick_cnt_next = tick_cnt_reg + 7'h01;
      end
    end
  end

  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      tick_cnt_reg <= 7'h00;
      spread_update_tick <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      spread_update_tick <= tick_next;
    end
  end

endmodule // cgc_config_regs

/* rtl/cgc_i2c_write.v */
`timescale 1ns/1ps
`include "cgc_regs.vh"

module cgc_i2c_write #(
  parameter [6:0] SLAVE_ADDR = `CGC_SLAVE_ADDR
) (
  input wire mclk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg wr_strobe,
  output reg [7:0] wr_addr,
  output reg [7:0] wr_data
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_ACK = 3'b100;
  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_SUB = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg scl_q_reg;
  reg sda_q_reg;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;

  assign scl_rise = scl_in & ~scl_q_reg;
  assign scl_fall = ~scl_in & scl_q_reg;
  assign bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign bus_stop = scl_in & scl_q_reg & ~sda_q_reg & sda_in;

  // Reads are not acknowledged because every register here is write-only.
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      sda_out <= 1'b0;
      wr_strobe <= 1'b0;
      if (bus_start)
      begin
        state_reg <= ST_SHIFT;
        phase_reg <= PH_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            sda_oe <= 1'b0;
          end
          ST_SHIFT:
          begin
            if (scl_rise && bit_cnt_reg != `CGC_I2C_BITS)
            begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == `CGC_I2C_BITS)
            begin
              if (phase_reg == PH_ADDR && shift_reg != {SLAVE_ADDR, 1'b0})
              begin
                state_reg <= ST_IDLE;
              end
              else
              begin
                state_reg <= ST_ACK;
                sda_oe <= 1'b1;
                if (phase_reg == PH_SUB)
                begin
                  wr_addr <= shift_reg;
                end
                if (phase_reg == PH_DATA)
                begin
                  wr_data <= shift_reg;
                  wr_strobe <= 1'b1;
                end
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              state_reg <= ST_SHIFT;
              bit_cnt_reg <= 4'h0;
              if (phase_reg == PH_DATA)
              begin
                wr_addr <= wr_addr + 8'h01;
              end
              else
              begin
                phase_reg <= phase_reg + 2'h1;
              end
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // cgc_i2c_write

/* rtl/cgc_regs.vh */
// How it works
// [RULE_01] Channel 2: VCO divider above output divider.
// [RULE_02] Channel 3 uses the same divider layout.
// [RULE_03] Signed 8-bit spread step size stored.
// [RULE_04] Nine-bit step count across two registers.
// [RULE_05] Update tick divides reference tick by divisor.
// [RULE_06] Alternate PLL1 loop ratio used when pin high.
// [RULE_07] Alternate channel 0 and 1 dividers.
// [RULE_08] Alternate PLL2 loop ratio used when pin high.
// [RULE_09] Alternate numerator and denominator span three registers.
// [RULE_10] Alternate channel 3 below channel 2 address.
// [RULE_11] Output styles and channel 2/3 powerdowns decoded.
// [RULE_12] Alternate set applies only while pin high.
// [RULE_13] PLL powerdowns and reference divider select bit.
`ifndef CGC_REGS_VH
`define CGC_REGS_VH

`define CGC_SLAVE_ADDR 7'h40

`define CGC_OFF_CH2_DIV 8'h25
`define CGC_OFF_CH3_DIV 8'h26
`define CGC_OFF_CH_SYNC 8'h27
`define CGC_OFF_STEP_SIZE 8'h2a
`define CGC_OFF_COUNT_HIGH 8'h2b
`define CGC_OFF_COUNT_LOW_RATE 8'h2c
`define CGC_OFF_ALT_PLL1_FB 8'h30
`define CGC_OFF_ALT_CH0_DIV 8'h31
`define CGC_OFF_ALT_CH1_DIV 8'h32
`define CGC_OFF_ALT_PLL2_FB 8'h33
`define CGC_OFF_ALT_NUM_HIGH 8'h34
`define CGC_OFF_ALT_NUM_DEN 8'h35
`define CGC_OFF_ALT_DEN_LOW 8'h36
`define CGC_OFF_ALT_CH3_DIV 8'h37
`define CGC_OFF_ALT_CH2_DIV 8'h38
`define CGC_OFF_FORMAT_PD 8'h3a
`define CGC_OFF_REF_OUT_PD 8'h3b
`define CGC_OFF_PLL_PD 8'h3d

`define CGC_RST_CH2_DIV 8'h86
`define CGC_RST_CH3_DIV 8'h92
`define CGC_RST_ALT_PLL1_FB 6'h14
`define CGC_RST_ALT_CH0_DIV 8'h84
`define CGC_RST_ALT_CH1_DIV 8'h85
`define CGC_RST_ALT_PLL2_FB 6'h16
`define CGC_RST_ALT_CH3_DIV 8'h86
`define CGC_RST_ALT_CH2_DIV 8'h46

`define CGC_BIT_COUNT_LSB 7
`define CGC_BIT_CH2_PD 6
`define CGC_BIT_CH3_PD 7
`define CGC_BIT_PLL1_PD 3
`define CGC_BIT_PLL2_PD 2
`define CGC_BIT_REF_DIV 1
`define CGC_BIT_SYNC 0
`define CGC_BIT_REF_OUT_PD 0

`define CGC_I2C_BITS 4'h8

`endif

/* testbench/cgc_config_checker.sv */
`timescale 1ns/1ps
module cgc_config_checker (
  input wire mclk,
  input wire nrst,
  input wire alt_freq_select_pin,
  input wire ref_div_tick,
  input wire [5:0] norm_pll1_loop_ratio,
  input wire [7:0] norm_ch0_div,
  input wire [7:0] norm_ch1_div,
  input wire [5:0] norm_pll2_loop_ratio,
  input wire [11:0] norm_sigma_delta_numerator,
  input wire [11:0] norm_sigma_delta_denominator,
  input wire [2:0] ch0_vco_div,
  input wire [4:0] ch0_out_div,
  input wire [2:0] ch1_vco_div,
  input wire [4:0] ch1_out_div,
  input wire [5:0] pll1_loop_ratio,
  input wire [5:0] pll2_loop_ratio,
  input wire [11:0] sigma_delta_numerator,
  input wire [11:0] sigma_delta_denominator,
  input wire [6:0] spread_update_divisor,
  input wire spread_update_tick
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  norm_ch0_a:
    assert property (!alt_freq_select_pin |=> {ch0_vco_div, ch0_out_div} == $past(norm_ch0_div))
      else $error("channel 0 divider not from normal set");
  norm_ch1_a:
    assert property (!alt_freq_select_pin |=> {ch1_vco_div, ch1_out_div} == $past(norm_ch1_div))
      else $error("channel 1 divider not from normal set");
  norm_ratio1_a:
    assert property (!alt_freq_select_pin |=> pll1_loop_ratio == $past(norm_pll1_loop_ratio))
      else $error("pll1 ratio not from normal set");
  norm_ratio2_a:
    assert property (!alt_freq_select_pin |=> pll2_loop_ratio == $past(norm_pll2_loop_ratio))
      else $error("pll2 ratio not from normal set");
  norm_fraction_a:
    assert property (!alt_freq_select_pin |=> sigma_delta_numerator == $past(norm_sigma_delta_numerator)
      && sigma_delta_denominator == $past(norm_sigma_delta_denominator))
      else $error("fraction words not from normal set");
  tick_cause_a:
    assert property (spread_update_tick |-> $past(ref_div_tick))
      else $error("update tick without reference tick");
  tick_zero_a:
    assert property (spread_update_divisor == 7'h00 |=> !spread_update_tick)
      else $error("update tick with zero divisor");
  tick_every_a:
    assert property (ref_div_tick && spread_update_divisor == 7'h01 |=> spread_update_tick)
      else $error("divisor one missed a tick");
  // Divisors above one may never give back-to-back ticks.
  tick_gap_a:
    assert property (spread_update_tick && spread_update_divisor > 7'h01 |=> !spread_update_tick)
      else $error("update ticks too close");
endmodule // cgc_config_checker

bind cgc_config_regs cgc_config_checker chk_u (.mclk, .nrst, .alt_freq_select_pin, .ref_div_tick,
  .norm_pll1_loop_ratio, .norm_ch0_div, .norm_ch1_div, .norm_pll2_loop_ratio, .norm_sigma_delta_numerator,
  .norm_sigma_delta_denominator, .ch0_vco_div, .ch0_out_div, .ch1_vco_div, .ch1_out_div, .pll1_loop_ratio,
  .pll2_loop_ratio, .sigma_delta_numerator, .sigma_delta_denominator, .spread_update_divisor,
  .spread_update_tick);

/* testbench/cgc_i2c_host.sv */
`timescale 1ns/1ps
module cgc_i2c_host (
  input wire mclk,
  input wire sda_line,
  output logic scl,
  output logic sda_rel
);
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Four clocks per level leaves three over the one the device needs.
  task automatic hold;
    repeat (4) @(negedge mclk);
  endtask
  task automatic start;
    sda_rel = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_rel = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop;
    sda_rel = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_rel = 1'b1;
    hold();
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_rel = b[i];
      hold();
      scl = 1'b1;
      hold();
      scl = 1'b0;
      hold();
    end
    sda_rel = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    ack = !sda_line;
    scl = 1'b0;
    hold();
  endtask
endmodule // cgc_i2c_host

/* testbench/test_cgc_config_regs.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module test_cgc_config_regs;
  logic mclk = 1'b0, nrst = 1'b0, alt = 1'b0, rtick = 1'b0, ack;
  logic [5:0] n_r1 = 6'h11, n_r2 = 6'h22;
  logic [7:0] n_c0 = 8'h33, n_c1 = 8'h44;
  logic [11:0] n_num = 12'h555, n_den = 12'h666;
  int failures = 0, cmp_count = 0, nt = 0;
  wire scl, sda_rel, sda_oe, sda_out;
  // Open-drain line with pull-up: the device's level counts only while its enable is high.
  wire sda = sda_rel & (sda_oe ? sda_out : 1'b1);
  wire [2:0] v0, v1, v2, v3, s1, s2;
  wire [4:0] d0, d1, d2, d3;
  wire [5:0] r1, r2;
  wire [11:0] num, den;
  wire [7:0] step;
  wire [8:0] cnt;
  wire [6:0] div;
  wire algn, tick, pd2, pd3, rof, p1off, p2off, rdiv;
  cgc_i2c_host host_u (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_rel(sda_rel));
  cgc_config_regs dut_u (.mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .alt_freq_select_pin(alt), .ref_div_tick(rtick), .norm_pll1_loop_ratio(n_r1), .norm_ch0_div(n_c0),
    .norm_ch1_div(n_c1), .norm_pll2_loop_ratio(n_r2), .norm_sigma_delta_numerator(n_num),
    .norm_sigma_delta_denominator(n_den), .ch0_vco_div(v0), .ch0_out_div(d0), .ch1_vco_div(v1),
    .ch1_out_div(d1), .ch2_vco_div(v2), .ch2_out_div(d2), .ch3_vco_div(v3), .ch3_out_div(d3),
    .pll1_loop_ratio(r1), .pll2_loop_ratio(r2), .sigma_delta_numerator(num), .sigma_delta_denominator(den),
    .pll2_channel_align(algn), .spread_step_size(step), .spread_step_count(cnt), .spread_update_divisor(div),
    .spread_update_tick(tick), .pll1_output_style(s1), .pll2_output_style(s2), .ch2_powerdown(pd2),
    .ch3_powerdown(pd3), .refclk_output_off(rof), .pll1_off(p1off), .pll2_off(p2off), .ref_div_by_two(rdiv));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (tick !== 1'b0)
      nt++;
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rst;
    nrst = 1'b0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [63:0] d, input int n);
    host_u.start();
    host_u.send(8'h80, ack);
    `CHK(ack, 1'b1)
    host_u.send(sub, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      host_u.send(d[63 - 8 * i -: 8], ack);
      `CHK(ack, 1'b1)
    end
    host_u.stop();
  endtask
  task automatic bad(input logic [7:0] a);
    host_u.start();
    host_u.send(a, ack);
    host_u.stop();
    `CHK(ack, 1'b0)
  endtask
  task automatic pulses(input logic [7:0] d, input int n, input int e);
    wr(8'h2c, {d, 56'h0}, 1);
    nt = 0;
    repeat (n)
    begin
      @(negedge mclk) rtick = 1'b1;
      @(negedge mclk) rtick = 1'b0;
      @(negedge mclk);
    end
    `CHK(nt, e)
  endtask
  task automatic setalt(input logic v);
    alt = v;
    repeat (2) @(negedge mclk);
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    failures++;
    results();
  end
  initial
  begin
    @(negedge mclk);
    rst();
    `CHK({v2, d2, v3, d3}, 16'h8692)
    `CHK({v0, d0, v1, d1, r1, r2}, {n_c0, n_c1, n_r1, n_r2})
    `CHK({num, den, step, cnt, div}, {n_num, n_den, 24'h0})
    setalt(1'b1);
    `CHK({v0, d0, v1, d1, v2, d2, v3, d3}, 32'h84854686)
    `CHK({r1, r2, num, den}, {6'h14, 6'h16, 24'h0})
    $display("Test defaults done");
    wr(8'h30, 64'hffa162c5_00000000, 4);
    wr(8'h34, 64'habcdef3edb_000000, 5);
    `CHK({r1, v0, d0, v1, d1, r2}, {6'h3f, 8'ha1, 8'h62, 6'h05})
    `CHK({num, den}, 24'habcdef)
    `CHK({v3, d3, v2, d2}, 16'h3edb)
    n_c0 = 8'hc3;
    n_r1 = 6'h2a;
    n_num = 12'h9a5;
    setalt(1'b0);
    `CHK({v0, d0, r1, num}, {8'hc3, 6'h2a, 12'h9a5})
    $display("Test alternate set done");
    wr(8'h25, 64'ha75c01_0000000000, 3);
    `CHK({v2, d2, v3, d3, algn}, {16'ha75c, 1'b1})
    wr(8'h2a, 64'hf91689_0000000000, 3);
    `CHK({step, cnt, div}, {8'hf9, 9'h02d, 7'h09})
    wr(8'h3a, 64'he301ff0a_00000000, 4);
    `CHK({pd3, pd2, s2, s1, rof}, {2'b11, 3'h4, 3'h3, 1'b1})
    `CHK({p1off, p2off, rdiv}, 3'h5)
    wr(8'h3d, 64'h04_00000000000000, 1);
    `CHK({p1off, p2off, rdiv}, 3'h2)
    $display("Test control bits done");
    bad(8'h82);
    bad(8'h81);
    wr(8'h28, 64'h5a5a_000000000000, 2);
    `CHK({v2, d2, v3, d3, algn, step}, {16'ha75c, 1'b1, 8'hf9})
    $display("Test refusals done");
    pulses(8'h03, 9, 3);
    `CHK(cnt, 9'h02c)
    pulses(8'h00, 6, 0);
    pulses(8'h01, 4, 4);
    $display("Test update tick done");
    rst();
    `CHK({v2, d2, step, p1off}, {16'h8600, 1'b0})
    $display("Test second reset done");
    results();
  end
endmodule // test_cgc_config_regs
